//--- ipsm_pkg.sv
// shared constants, field positions and the raw-condition carrier for the irq2 block
`default_nettype none
package ipsm_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [13:0] IDX_MEMIF_FLAGS = 14'h191f;
  localparam logic [13:0] IDX_BUSERR_FLAGS = 14'h1920;
  localparam logic [13:0] IDX_MEMIF_MASK = 14'h195f;
  localparam logic [13:0] IDX_BUSERR_MASK = 14'h1960;
  localparam logic [13:0] IDX_RAW_BOOT = 14'h1980;
  localparam logic [13:0] IDX_RAW_CLOCK = 14'h1981;
  localparam logic [13:0] IDX_RAW_ACC = 14'h1986;
  localparam logic [13:0] IDX_RAW_LOCK = 14'h1988;
  localparam logic [13:0] IDX_RAW_SHORT = 14'h198b;
  localparam logic [13:0] IDX_RAW_UP = 14'h198c;
  localparam logic [13:0] IDX_RAW_DOWN = 14'h198d;
  localparam logic [13:0] IDX_RAW_PIN_LO = 14'h1990;
  localparam logic [13:0] IDX_RAW_PIN_MID = 14'h1991;
  localparam logic [13:0] IDX_RAW_PIN_HI = 14'h1992;
  localparam logic [13:0] IDX_RAW_LOG_NE = 14'h1995;
  localparam logic [13:0] IDX_RAW_LOG_FULL = 14'h1996;
  localparam logic [13:0] IDX_RAW_LOG_WM = 14'h1997;
  localparam logic [13:0] IDX_RAW_DMA = 14'h1998;
  localparam logic [13:0] IDX_RAW_BUSY = 14'h199d;
  localparam logic [13:0] IDX_CTRL_FIRST = 14'h1a80;
  localparam logic [13:0] IDX_CTRL_SECOND = 14'h1a82;
  localparam logic [13:0] IDX_OUT_STATE = 14'h1aa0;

  // field positions
  localparam int BIT_HOST_ERR = 12;
  localparam int BIT_STARTUP = 7;
  localparam int BIT_REF_LOST = 15;
  localparam int BIT_CORE_CLK = 14;
  localparam int BIT_SEC_CLK = 13;
  localparam int BIT_MAIN_CLK = 12;
  localparam int BIT_LOOP_AO = 11;
  localparam int BIT_LOOP_TWO = 9;
  localparam int BIT_LOOP_ONE = 8;
  localparam int BIT_MIC_CLAMP = 4;
  localparam int BIT_JACK_TWO = 2;
  localparam int BIT_JACK_ONE = 0;
  localparam int BIT_RC_LOCK = 8;
  localparam int BIT_INPUT_SIG = 2;
  localparam int BIT_DYN_SIG = 0;
  localparam int BIT_OUT_MASK = 11;
  localparam int BIT_POL = 10;
  localparam int BIT_SECOND_STATE = 1;
  localparam int BIT_FIRST_STATE = 0;
  localparam int PIN_HI_SHIFT = 10;

  // counts and reset values
  localparam int NUM_CORES = 7;
  localparam int NUM_FLAGS = NUM_CORES + 1;
  localparam logic RST_FLAG_MASK = 1'b1;
  localparam logic RST_OUT_MASK = 1'b0;
  localparam logic RST_POL = 1'b1;

  typedef enum logic {BUS_IDLE, BUS_ANSWER} ipsm_bus_e;

  // live conditions fed in from the rest of the chip
  typedef struct packed {
    logic host_port_error_raw;
    logic startup_complete_raw;
    logic always_on_loop_ref_lost_raw;
    logic core_clock_shortfall_raw;
    logic second_domain_clock_shortfall_raw;
    logic main_clock_shortfall_raw;
    logic [2:0] loop_lock_raw;
    logic [3:0] rate_converter_lock_raw;
    logic mic_detect_clamp_raw;
    logic jack_one_pin;
    logic jack_two_pin;
    logic input_path_signal_raw;
    logic [1:0] dynamics_signal_raw;
    logic [5:0] phones_short_raw;
    logic [5:0] phones_power_up_done_raw;
    logic [5:0] phones_power_down_done_raw;
    logic [37:0] pin_level_raw;
    logic [7:0] log_fifo_nonempty_raw;
    logic [7:0] log_fifo_full_raw;
    logic [7:0] log_fifo_threshold_raw;
    logic [6:0] core_transfer_done_raw;
    logic [6:0] core_active_raw;
  } ipsm_raw_s;

endpackage : ipsm_pkg
`default_nettype wire

//--- ipsm_flag_bank.sv
// bank of rising-edge latched flags with write-one clear
`default_nettype none
module ipsm_flag_bank #(
  parameter int W = 8
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [W-1:0] src,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] flags
);

  logic [W-1:0] prev_r;
  logic [W-1:0] prev_nxt;
  logic [W-1:0] flags_r;
  logic [W-1:0] flags_nxt;

  // set term is or-ed in last so an edge in a clear cycle survives
  always_comb begin
    prev_nxt = src;
    flags_nxt = (flags_r & ~clr) | (src & ~prev_r);
  end

  // prev resets high: a source already high at release is not an edge
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prev_r <= '1;
      flags_r <= '0;
    end else begin
      prev_r <= prev_nxt;
      flags_r <= flags_nxt;
    end
  end

  assign flags = flags_r;

endmodule : ipsm_flag_bank
`default_nettype wire

//--- ipsm_irq2_ctrl.sv
// second interrupt group: latched flags, masks, raw status and request outputs
//
// Behaviour
// - each of seven cores latches a bus-error flag, bits 6..0, on rising edge
// - a latched flag clears only when one is written to it; zero keeps it
// - memory-interface block event latches bit 0 on rising edge, resets to zero
// - boot register bit 12 shows the live host-port error condition
// - boot register bit 7 reads zero during boot, one once finished
// - clock register bit 15 shows always-on loop reference lost
// - clock register bit 14 shows core clock shortfall
// - clock register bits 13 and 12 show second-domain and main clock shortfall
// - lock register bits 11..8 show four rate-converter input locks
// - accessory register bit 4 shows microphone-detect clamp active
// - accessory bits 2 and 0 read one when jack pin is driven low
// - lock register bits 2,1,0 show input path and dynamics signal detect
// - short register bits 5..0 show short on each headphone channel
// - separate power-up and power-down done bits for six headphone channels
// - levels of 38 general pins spread over three raw registers
// - eight log fifos report non-empty, full and watermark in three registers
// - per core transfer-done bit reads one when all buffers are serviced
// - first control bit 11, reset zero, masks the first request output
// - first control bit 10, reset one, selects output polarity, one is active low
// - second request state is the or of unmasked latched flags
// - second control bit 11, reset zero, masks the second request output
`default_nettype none
module ipsm_irq2_ctrl (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire ipsm_pkg::ipsm_raw_s raw_in,
  input wire logic [6:0] core_bus_error_src,
  input wire logic memif_block_src,
  input wire logic first_group_pending,
  output logic irq1_out,
  output logic irq2_out
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // low half-word of the write data gated by its byte lanes
  function automatic logic [15:0] lane_bits(input logic [31:0] wd, input logic [3:0] be);
    lane_bits = wd[15:0] & {{8{be[1]}}, {8{be[0]}}};
  endfunction : lane_bits

  // merge a write into an existing half-word
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
    logic [15:0] keep;
    keep = {{8{be[1]}}, {8{be[0]}}};
    lane_merge = (old & ~keep) | (wd[15:0] & keep);
  endfunction : lane_merge

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  localparam int NF = ipsm_pkg::NUM_FLAGS;
  localparam int NC = ipsm_pkg::NUM_CORES;

  logic [13:0] idx;
  ipsm_pkg::ipsm_bus_e bus_r;
  ipsm_pkg::ipsm_bus_e bus_nxt;
  logic wait_r;
  logic wait_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic write_take;
  logic read_start;
  logic [15:0] rd_word;
  logic [15:0] wr_bits;

  logic [NF-1:0] flag_src;
  logic [NF-1:0] flag_clr;
  logic [NF-1:0] flags;
  logic [NF-1:0] mask_r;
  logic [NF-1:0] mask_nxt;
  logic mask1_r;
  logic mask1_nxt;
  logic pol_r;
  logic pol_nxt;
  logic mask2_r;
  logic mask2_nxt;

  logic pend2;
  logic state2_r;
  logic state2_nxt;
  logic state1_r;
  logic state1_nxt;
  logic irq1_r;
  logic irq1_nxt;
  logic irq2_r;
  logic irq2_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave

  // low two address bits are ignored; every register is one aligned word
  assign idx = avs_address[15:2];
  assign read_start = (bus_r == ipsm_pkg::BUS_IDLE) && avs_read;
  // a write lands only at the edge where waitrequest is seen low
  assign write_take = (bus_r == ipsm_pkg::BUS_ANSWER) && avs_write;
  assign wr_bits = lane_bits(avs_writedata, avs_byteenable);

  // fixed one-cycle wait, then one answer cycle, then idle again
  always_comb begin
    bus_nxt = bus_r;
    case (bus_r)
      ipsm_pkg::BUS_IDLE: begin
        if (avs_read || avs_write) begin
          bus_nxt = ipsm_pkg::BUS_ANSWER;
        end
      end
      ipsm_pkg::BUS_ANSWER: begin
        bus_nxt = ipsm_pkg::BUS_IDLE;
      end
      default: begin
        bus_nxt = ipsm_pkg::BUS_IDLE;
      end
    endcase
    wait_nxt = (bus_nxt != ipsm_pkg::BUS_ANSWER);
    rdata_nxt = rdata_r;
    if (read_start) begin
      rdata_nxt = {16'h0000, rd_word};
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bus_r <= ipsm_pkg::BUS_IDLE;
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      bus_r <= bus_nxt;
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // read decode; raw words are live and side-effect free

  always_comb begin
    rd_word = 16'h0000; // unmapped and reserved bits read zero
    case (idx)
      ipsm_pkg::IDX_MEMIF_FLAGS: rd_word[0] = flags[0];
      ipsm_pkg::IDX_BUSERR_FLAGS: rd_word[NC-1:0] = flags[NF-1:1];
      ipsm_pkg::IDX_MEMIF_MASK: rd_word[0] = mask_r[0];
      ipsm_pkg::IDX_BUSERR_MASK: rd_word[NC-1:0] = mask_r[NF-1:1];
      ipsm_pkg::IDX_RAW_BOOT: begin
        rd_word[ipsm_pkg::BIT_HOST_ERR] = raw_in.host_port_error_raw;
        rd_word[ipsm_pkg::BIT_STARTUP] = raw_in.startup_complete_raw;
      end
      ipsm_pkg::IDX_RAW_CLOCK: begin
        rd_word[ipsm_pkg::BIT_REF_LOST] = raw_in.always_on_loop_ref_lost_raw;
        rd_word[ipsm_pkg::BIT_CORE_CLK] = raw_in.core_clock_shortfall_raw;
        rd_word[ipsm_pkg::BIT_SEC_CLK] = raw_in.second_domain_clock_shortfall_raw;
        rd_word[ipsm_pkg::BIT_MAIN_CLK] = raw_in.main_clock_shortfall_raw;
        rd_word[ipsm_pkg::BIT_LOOP_AO] = raw_in.loop_lock_raw[2];
        rd_word[ipsm_pkg::BIT_LOOP_TWO] = raw_in.loop_lock_raw[1];
        rd_word[ipsm_pkg::BIT_LOOP_ONE] = raw_in.loop_lock_raw[0];
      end
      ipsm_pkg::IDX_RAW_ACC: begin
        rd_word[ipsm_pkg::BIT_MIC_CLAMP] = raw_in.mic_detect_clamp_raw;
        // pin pulled low on insertion, so present is the inverted level
        rd_word[ipsm_pkg::BIT_JACK_TWO] = !raw_in.jack_two_pin;
        rd_word[ipsm_pkg::BIT_JACK_ONE] = !raw_in.jack_one_pin;
      end
      ipsm_pkg::IDX_RAW_LOCK: begin
        rd_word[ipsm_pkg::BIT_RC_LOCK+:4] = raw_in.rate_converter_lock_raw;
        rd_word[ipsm_pkg::BIT_INPUT_SIG] = raw_in.input_path_signal_raw;
        rd_word[ipsm_pkg::BIT_DYN_SIG+:2] = raw_in.dynamics_signal_raw;
      end
      ipsm_pkg::IDX_RAW_SHORT: rd_word[5:0] = raw_in.phones_short_raw;
      ipsm_pkg::IDX_RAW_UP: rd_word[5:0] = raw_in.phones_power_up_done_raw;
      ipsm_pkg::IDX_RAW_DOWN: rd_word[5:0] = raw_in.phones_power_down_done_raw;
      // pin level only meaningful for pins set up as general inputs
      ipsm_pkg::IDX_RAW_PIN_LO: rd_word = raw_in.pin_level_raw[15:0];
      ipsm_pkg::IDX_RAW_PIN_MID: rd_word = raw_in.pin_level_raw[31:16];
      ipsm_pkg::IDX_RAW_PIN_HI: begin
        rd_word[ipsm_pkg::PIN_HI_SHIFT+:6] = raw_in.pin_level_raw[37:32];
      end
      ipsm_pkg::IDX_RAW_LOG_NE: rd_word[7:0] = raw_in.log_fifo_nonempty_raw;
      ipsm_pkg::IDX_RAW_LOG_FULL: rd_word[7:0] = raw_in.log_fifo_full_raw;
      ipsm_pkg::IDX_RAW_LOG_WM: rd_word[7:0] = raw_in.log_fifo_threshold_raw;
      ipsm_pkg::IDX_RAW_DMA: rd_word[NC-1:0] = raw_in.core_transfer_done_raw;
      ipsm_pkg::IDX_RAW_BUSY: rd_word[NC-1:0] = raw_in.core_active_raw;
      ipsm_pkg::IDX_CTRL_FIRST: begin
        rd_word[ipsm_pkg::BIT_OUT_MASK] = mask1_r;
        rd_word[ipsm_pkg::BIT_POL] = pol_r;
      end
      ipsm_pkg::IDX_CTRL_SECOND: rd_word[ipsm_pkg::BIT_OUT_MASK] = mask2_r;
      ipsm_pkg::IDX_OUT_STATE: begin
        rd_word[ipsm_pkg::BIT_SECOND_STATE] = state2_r;
        rd_word[ipsm_pkg::BIT_FIRST_STATE] = state1_r;
      end
      default: rd_word = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // latched flags; bit 0 memory block, bits 7..1 core bus errors

  assign flag_src = {core_bus_error_src, memif_block_src};

  // write-one clear; raw registers have no write path at all
  always_comb begin
    flag_clr = '0;
    if (write_take && idx == ipsm_pkg::IDX_MEMIF_FLAGS) begin
      flag_clr[0] = wr_bits[0];
    end
    if (write_take && idx == ipsm_pkg::IDX_BUSERR_FLAGS) begin
      flag_clr[NF-1:1] = wr_bits[NC-1:0];
    end
  end

  ipsm_flag_bank #(
    .W(NF)
  ) u_flags (
    .core_clk(core_clk),
    .rstn(rstn),
    .src(flag_src),
    .clr(flag_clr),
    .flags(flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // mask and output-control registers

  // boot gating of writes is left to software; nothing is refused here
  always_comb begin
    logic [15:0] m;
    logic [15:0] c1;
    logic [15:0] c2;
    m = 16'h0000;
    c1 = 16'h0000;
    c2 = 16'h0000;
    mask_nxt = mask_r;
    mask1_nxt = mask1_r;
    pol_nxt = pol_r;
    mask2_nxt = mask2_r;
    if (write_take && idx == ipsm_pkg::IDX_MEMIF_MASK) begin
      m = lane_merge({15'h0000, mask_r[0]}, avs_writedata, avs_byteenable);
      mask_nxt[0] = m[0];
    end
    if (write_take && idx == ipsm_pkg::IDX_BUSERR_MASK) begin
      m = lane_merge({9'h000, mask_r[NF-1:1]}, avs_writedata, avs_byteenable);
      mask_nxt[NF-1:1] = m[NC-1:0];
    end
    if (write_take && idx == ipsm_pkg::IDX_CTRL_FIRST) begin
      c1 = lane_merge(16'h0000, avs_writedata, avs_byteenable);
      if (avs_byteenable[1]) begin
        mask1_nxt = c1[ipsm_pkg::BIT_OUT_MASK];
        pol_nxt = c1[ipsm_pkg::BIT_POL];
      end
    end
    if (write_take && idx == ipsm_pkg::IDX_CTRL_SECOND) begin
      c2 = lane_merge(16'h0000, avs_writedata, avs_byteenable);
      if (avs_byteenable[1]) begin
        mask2_nxt = c2[ipsm_pkg::BIT_OUT_MASK];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mask_r <= {NF{ipsm_pkg::RST_FLAG_MASK}};
      mask1_r <= ipsm_pkg::RST_OUT_MASK;
      pol_r <= ipsm_pkg::RST_POL;
      mask2_r <= ipsm_pkg::RST_OUT_MASK;
    end else begin
      mask_r <= mask_nxt;
      mask1_r <= mask1_nxt;
      pol_r <= pol_nxt;
      mask2_r <= mask2_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request state and pins

  assign pend2 = |(flags & ~mask_r);

  // pins idle at the polarity level: high out of reset, as polarity resets to one
  always_comb begin
    state2_nxt = pend2;
    state1_nxt = first_group_pending;
    irq2_nxt = pol_r ^ (pend2 & !mask2_r);
    irq1_nxt = pol_r ^ (first_group_pending & !mask1_r);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state2_r <= 1'b0;
      state1_r <= 1'b0;
      irq2_r <= ipsm_pkg::RST_POL;
      irq1_r <= ipsm_pkg::RST_POL;
    end else begin
      state2_r <= state2_nxt;
      state1_r <= state1_nxt;
      irq2_r <= irq2_nxt;
      irq1_r <= irq1_nxt;
    end
  end

  assign irq1_out = irq1_r;
  assign irq2_out = irq2_r;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  logic wr_buserr;
  assign wr_buserr = write_take && idx == ipsm_pkg::IDX_BUSERR_FLAGS && avs_byteenable[0];

  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  property p_bus_answer;
    (avs_read || avs_write) && avs_waitrequest |=> s_answer;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("answer not one cycle");

  property p_bus_err_set;
    $rose(core_bus_error_src[0]) |=> flags[1];
  endproperty
  a_bus_err_set: assert property (p_bus_err_set) else $error("bus error not latched");

  property p_memif_set;
    $rose(memif_block_src) |=> flags[0] ##1 flags[0] || $past(flag_clr[0]);
  endproperty
  a_memif_set: assert property (p_memif_set) else $error("block flag not latched");

  property p_w1c;
    wr_buserr && avs_writedata[0] && !$rose(core_bus_error_src[0]) |=> !flags[1];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");

  property p_zero_keeps;
    wr_buserr && !avs_writedata[0] && flags[1] |=> flags[1];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("write zero cleared flag");

  property p_set_wins;
    wr_buserr && avs_writedata[0] && $rose(core_bus_error_src[0]) |=> flags[1];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat set");

  property p_read_keeps;
    read_start && idx == ipsm_pkg::IDX_BUSERR_FLAGS && flags[1] && !flag_clr[1]
      |=> flags[1] ##1 avs_readdata[0];
  endproperty
  a_read_keeps: assert property (p_read_keeps) else $error("read disturbed flag");

  property p_mask_write;
    write_take && idx == ipsm_pkg::IDX_BUSERR_MASK && avs_byteenable[0]
      |=> mask_r[1] == $past(avs_writedata[0]);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask not written");

  property p_pin2;
    1'b1 |=> irq2_out == ($past(pol_r) ^ ($past(pend2) && !$past(mask2_r)));
  endproperty
  a_pin2: assert property (p_pin2) else $error("second pin wrong");

  property p_pin1_masked;
    mask1_r |=> irq1_out == $past(pol_r);
  endproperty
  a_pin1_masked: assert property (p_pin1_masked) else $error("first pin not masked");

  property p_state2;
    (flags & ~mask_r) == '0 ##1 (flags & ~mask_r) == '0 |-> !state2_r;
  endproperty
  a_state2: assert property (p_state2) else $error("state set without flag");

  property p_jack_read;
    read_start && idx == ipsm_pkg::IDX_RAW_ACC |=> avs_readdata[0] == !$past(raw_in.jack_one_pin);
  endproperty
  a_jack_read: assert property (p_jack_read) else $error("jack read wrong");

  property p_boot_read;
    read_start && idx == ipsm_pkg::IDX_RAW_BOOT
      |=> avs_readdata[7] == $past(raw_in.startup_complete_raw) && !avs_waitrequest;
  endproperty
  a_boot_read: assert property (p_boot_read) else $error("boot read wrong");

endmodule : ipsm_irq2_ctrl
`default_nettype wire

//--- ipsm_host_model.sv
// host-side partner: decodes the request pin and gates writes on boot status
`default_nettype none
module ipsm_host_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic irq_pin,
  input wire logic active_low,
  input wire logic boot_done,
  output logic pending,
  output logic writes_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  // pin level seen through the programmed polarity
  assign pending = irq_pin ^ active_low;
  // host holds off control writes until startup reports idle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      writes_ok <= 1'h0;
    end else begin
      writes_ok <= boot_done;
    end
  end
endmodule : ipsm_host_model
`default_nettype wire

//--- testbench.sv
// self-checking bench for the second interrupt group block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RW = $bits(ipsm_pkg::ipsm_raw_s);
  logic core_clk, rstn, avs_read, avs_write, avs_waitrequest, mpin, fgp, irq1_out, irq2_out;
  logic pol, pending, writes_ok;
  logic [15:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [6:0] bsrc;
  logic [15:0] rd;
  logic [127:0] pat;
  ipsm_pkg::ipsm_raw_s raw_in, r;
  int failures, num_checks, cyc, n;
  logic [13:0] raws[15] = '{ipsm_pkg::IDX_RAW_BOOT, ipsm_pkg::IDX_RAW_CLOCK,
    ipsm_pkg::IDX_RAW_ACC, ipsm_pkg::IDX_RAW_LOCK, ipsm_pkg::IDX_RAW_SHORT, ipsm_pkg::IDX_RAW_UP,
    ipsm_pkg::IDX_RAW_DOWN, ipsm_pkg::IDX_RAW_PIN_LO, ipsm_pkg::IDX_RAW_PIN_MID,
    ipsm_pkg::IDX_RAW_PIN_HI, ipsm_pkg::IDX_RAW_LOG_NE, ipsm_pkg::IDX_RAW_LOG_FULL,
    ipsm_pkg::IDX_RAW_LOG_WM, ipsm_pkg::IDX_RAW_DMA, ipsm_pkg::IDX_RAW_BUSY};
  ipsm_irq2_ctrl i_ipsm_irq2_ctrl (.core_clk(core_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .raw_in(raw_in), .core_bus_error_src(bsrc), .memif_block_src(mpin),
    .first_group_pending(fgp), .irq1_out(irq1_out), .irq2_out(irq2_out));
  ipsm_host_model i_ipsm_host_model (.core_clk(core_clk), .rstn(rstn), .irq_pin(irq2_out),
    .active_low(pol), .boot_done(raw_in.startup_complete_raw), .pending(pending),
    .writes_ok(writes_ok));
  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard; ceiling well above the few hundred bus cycles used
  initial begin
    core_clk = 1'h0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task end_sim;
    if (failures == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one avalon transfer; request held until waitrequest is sampled low
  // no local limit: a slave that never answers is caught by the cycle ceiling
  task bus(input logic w, input logic [13:0] idx, input logic [15:0] wd, output logic [15:0] d);
    @(posedge core_clk);
    avs_address <= {idx, 2'h0};
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {16'h0000, wd};
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'h0);
    d = avs_readdata[15:0];
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask : bus
  task wr(input logic [13:0] idx, input logic [15:0] wd);
    logic [15:0] d;
    bus(1'h1, idx, wd, d);
  endtask : wr
  task rdc(input string nm, input logic [13:0] idx, input logic [15:0] e);
    logic [15:0] d;
    bus(1'h0, idx, 16'h0000, d);
    chk(nm, {16'h0000, d}, {16'h0000, e});
  endtask : rdc
  // expected raw view from the live conditions; loop locks sit at bits 11, 9 and 8
  function automatic logic [15:0] exp_raw(input logic [13:0] i);
    ipsm_pkg::ipsm_raw_s x;
    x = raw_in;
    case (i)
      ipsm_pkg::IDX_RAW_BOOT: exp_raw = {3'h0, x.host_port_error_raw, 4'h0,
        x.startup_complete_raw, 7'h00};
      ipsm_pkg::IDX_RAW_CLOCK: exp_raw = {x.always_on_loop_ref_lost_raw,
        x.core_clock_shortfall_raw, x.second_domain_clock_shortfall_raw,
        x.main_clock_shortfall_raw, x.loop_lock_raw[2], 1'h0, x.loop_lock_raw[1:0], 8'h00};
      ipsm_pkg::IDX_RAW_ACC: exp_raw = {11'h000, x.mic_detect_clamp_raw, 1'h0,
        ~x.jack_two_pin, 1'h0, ~x.jack_one_pin};
      ipsm_pkg::IDX_RAW_LOCK: exp_raw = {4'h0, x.rate_converter_lock_raw, 5'h00,
        x.input_path_signal_raw, x.dynamics_signal_raw};
      ipsm_pkg::IDX_RAW_SHORT: exp_raw = {10'h000, x.phones_short_raw};
      ipsm_pkg::IDX_RAW_UP: exp_raw = {10'h000, x.phones_power_up_done_raw};
      ipsm_pkg::IDX_RAW_DOWN: exp_raw = {10'h000, x.phones_power_down_done_raw};
      ipsm_pkg::IDX_RAW_PIN_LO: exp_raw = x.pin_level_raw[15:0];
      ipsm_pkg::IDX_RAW_PIN_MID: exp_raw = x.pin_level_raw[31:16];
      ipsm_pkg::IDX_RAW_PIN_HI: exp_raw = {x.pin_level_raw[37:32], 10'h000};
      ipsm_pkg::IDX_RAW_LOG_NE: exp_raw = {8'h00, x.log_fifo_nonempty_raw};
      ipsm_pkg::IDX_RAW_LOG_FULL: exp_raw = {8'h00, x.log_fifo_full_raw};
      ipsm_pkg::IDX_RAW_LOG_WM: exp_raw = {8'h00, x.log_fifo_threshold_raw};
      ipsm_pkg::IDX_RAW_DMA: exp_raw = {9'h000, x.core_transfer_done_raw};
      default: exp_raw = {9'h000, x.core_active_raw};
    endcase
  endfunction : exp_raw
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rstn = 1'h0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_address = 16'h0000;
    avs_writedata = 32'h0000_0000;
    raw_in = '0;
    bsrc = 7'h00;
    mpin = 1'h0;
    fgp = 1'h0;
    pol = 1'h1;
    repeat (5) @(posedge core_clk);
    rstn <= 1'h1;
    rdc("boot", ipsm_pkg::IDX_RAW_BOOT, 16'h0000);
    rdc("bmask", ipsm_pkg::IDX_BUSERR_MASK, 16'h007f);
    rdc("mmask", ipsm_pkg::IDX_MEMIF_MASK, 16'h0001);
    rdc("ctl1", ipsm_pkg::IDX_CTRL_FIRST, 16'h0400);
    rdc("ctl2", ipsm_pkg::IDX_CTRL_SECOND, 16'h0000);
    rdc("bflag", ipsm_pkg::IDX_BUSERR_FLAGS, 16'h0000);
    rdc("mflag", ipsm_pkg::IDX_MEMIF_FLAGS, 16'h0000);
    rdc("unmapped", 14'h0100, 16'h0000);
    chk("irq2", irq2_out, 32'h1);
    raw_in.startup_complete_raw <= 1'h1;
    n = 0;
    while (writes_ok !== 1'h1 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    chk("boot_wait", writes_ok, 32'h1);
    // raw views under a pattern and its inverse; writes must bounce off
    for (int p = 0; p < 2; p++) begin
      pat = p ? ~{8{16'ha5c3}} : {8{16'ha5c3}};
      r = ipsm_pkg::ipsm_raw_s'(pat[RW-1:0]);
      r.startup_complete_raw = 1'h1;
      raw_in <= r;
      for (int k = 0; k < 15; k++) begin
        wr(raws[k], 16'hffff);
        bus(1'h0, raws[k], 16'h0000, rd);
        chk("raw", rd, exp_raw(raws[k]));
      end
    end
    // latched flags, masking and write-one clear
    bsrc <= 7'h49;
    mpin <= 1'h1;
    repeat (2) @(posedge core_clk);
    rdc("bflag", ipsm_pkg::IDX_BUSERR_FLAGS, 16'h0049);
    rdc("mflag", ipsm_pkg::IDX_MEMIF_FLAGS, 16'h0001);
    rdc("state", ipsm_pkg::IDX_OUT_STATE, 16'h0000);
    chk("pend", pending, 32'h0);
    wr(ipsm_pkg::IDX_BUSERR_MASK, 16'h0077);
    repeat (2) @(posedge core_clk);
    chk("pend", pending, 32'h1);
    rdc("state", ipsm_pkg::IDX_OUT_STATE, 16'h0002);
    wr(ipsm_pkg::IDX_BUSERR_FLAGS, 16'h0000);
    rdc("bflag", ipsm_pkg::IDX_BUSERR_FLAGS, 16'h0049);
    wr(ipsm_pkg::IDX_BUSERR_FLAGS, 16'h0041);
    rdc("bflag", ipsm_pkg::IDX_BUSERR_FLAGS, 16'h0008);
    bsrc <= 7'h00;
    // a fresh rise lands on the clearing edge and must win
    fork
      wr(ipsm_pkg::IDX_BUSERR_FLAGS, 16'h0009);
      begin
        repeat (2) @(posedge core_clk);
        bsrc <= 7'h09;
      end
    join
    rdc("bflag", ipsm_pkg::IDX_BUSERR_FLAGS, 16'h0009);
    wr(ipsm_pkg::IDX_MEMIF_FLAGS, 16'h0001);
    rdc("mflag", ipsm_pkg::IDX_MEMIF_FLAGS, 16'h0000);
    // polarity and output masks
    wr(ipsm_pkg::IDX_CTRL_FIRST, 16'h0000);
    pol = 1'h0;
    fgp <= 1'h1;
    repeat (2) @(posedge core_clk);
    chk("irq1", irq1_out, 32'h1);
    chk("irq2", irq2_out, 32'h1);
    wr(ipsm_pkg::IDX_CTRL_FIRST, 16'h0800);
    repeat (2) @(posedge core_clk);
    chk("irq1", irq1_out, 32'h0);
    wr(ipsm_pkg::IDX_CTRL_SECOND, 16'h0800);
    repeat (2) @(posedge core_clk);
    chk("irq2", irq2_out, 32'h0);
    rdc("state", ipsm_pkg::IDX_OUT_STATE, 16'h0003);
    wr(ipsm_pkg::IDX_CTRL_SECOND, 16'h0000);
    wr(ipsm_pkg::IDX_CTRL_FIRST, 16'h0400);
    pol = 1'h1;
    wr(ipsm_pkg::IDX_BUSERR_FLAGS, 16'h0008);
    repeat (2) @(posedge core_clk);
    chk("pend", pending, 32'h0);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
